// ===== logic/idt_identify_words.sv
// AHB-Lite slave holding the live and fixed identify data words 6 to 64
`timescale 1ns/100ps
`default_nettype none

module idt_identify_words (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  import idt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus register map, byte offsets
  //   000  default sectors per track
  //   004  card sector count
  //   008  cylinders, heads, sectors
  //   00c  multiple maximum and current
  //   010  mode and capability control
  //   014  capacity, read only
  //   400  identify window, 4 per word
  //   Others read zero, drop writes
  //
  // Control word fields
  //   0      standby timer flag
  //   1      flow control flag
  //   5-4    pio mode, clamped to 2
  //   9-8    dma select, 3 is none
  //   13-12  dma support count
  //   17-16  advanced pio bits
  //
  // Identify window words
  //   0-5    not ours, zero
  //   6      default sectors
  //   7-8    card sectors, low first
  //   9      zero
  //   10-19  serial text
  //   20-21  zero
  //   22     ecc byte count
  //   23-26  firmware text
  //   27-46  model text
  //   47     multiple maximum
  //   48     zero
  //   49     capabilities
  //   50     zero
  //   51     pio mode
  //   52     zero
  //   53     validity flags
  //   54     current cylinders
  //   55     current heads
  //   56     current sectors
  //   57-58  capacity, low first
  //   59     multiple setting
  //   60-61  lba sectors, low first
  //   62     zero
  //   63     multiword dma
  //   64     advanced pio
  //   65 up  not ours, zero
  //
  // Word 47
  //   15-8   80h if preferred, else 00h
  //   7-0    multiple maximum
  //
  // Capability word
  //   13     standby per idle command
  //   11     flow control guaranteed
  //   10     zero, cannot disable
  //   9      one, lba always there
  //   8      zero, no plain dma
  //   Others zero
  //
  // Word 51
  //   9-8    pio mode 0 to 2
  //   Others zero
  //
  // Validity word
  //   0      one, words 54-58 live
  //   1      set with any upper mode
  //   Others zero
  //
  // Word 59
  //   8      one, setting valid
  //   7-0    current multiple count
  //   Others zero
  //
  // Dma word
  //   15-11  zero, high modes elsewhere
  //   10-8   one-hot selection
  //   7-3    zero
  //   2-0    cumulative support
  //
  // Word 64
  //   0      pio mode 3 supported
  //   1      pio mode 4 supported
  //   Others zero
  //
  // Text words
  //   First character in upper byte
  //   Zero bytes read as spaces
  //   Software owns alignment
  //   Reset fills with spaces

  idt_state_type stateQ;
  idt_state_type stateD;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  //   Text slot map shared by read
  //   and write paths; word fetch
  //   shared by every window read

  // Null characters read as space so unused positions are always padded
  function automatic logic [7:0] padChar(input logic [7:0] c);
    padChar = (c == 8'h00) ? IDT_SPACE : c;
  endfunction : padChar

  // Map identify word number to text slot; returns valid flag in bit 6
  function automatic logic [6:0] textSlot(input logic [7:0] w);
    textSlot = 7'h00;
    if (w >= 8'd10 && w <= 8'd19) begin
      textSlot = {1'b1, 6'(w - 8'd10)};
    end else if (w >= 8'd23 && w <= 8'd46) begin
      textSlot = {1'b1, 6'(w - 8'd13)};
    end
  endfunction : textSlot

  // Cumulative support mask for multiword DMA modes 0..2
  function automatic logic [7:0] dmaSupMask(input logic [1:0] n);
    unique case (n)
      2'h0: dmaSupMask = 8'h00;
      2'h1: dmaSupMask = 8'h01;
      2'h2: dmaSupMask = 8'h03;
      2'h3: dmaSupMask = 8'h07;
    endcase
  endfunction : dmaSupMask

  // Fetch one identify word from the current state
  function automatic logic [15:0] identWord(input idt_state_type s, input logic [7:0] w);
    logic [6:0]  slot;
    logic [15:0] t;
    slot      = textSlot(w);
    t         = s.text[slot[5:0]];
    identWord = 16'h0000;
    if (slot[6]) begin
      identWord = {padChar(t[15:8]), padChar(t[7:0])};
    end else begin
      unique case (w)
        8'd6:  identWord = s.defSpt;
        8'd7:  identWord = s.cardSectors[15:0];
        8'd8:  identWord = s.cardSectors[31:16];
        8'd22: identWord = IDT_ECC_COUNT;
        8'd47: identWord = {s.multiPref ? IDT_MUL_PREF : 8'h00, s.multiMax};
        // Bits 10 and 8 stay zero, bit 9 stays one
        8'd49: identWord = {2'b00, s.standby, 1'b0, s.iordy, 1'b0, 1'b1, 1'b0, 8'h00};
        8'd51: identWord = {6'h00, s.pioMode, 8'h00};
        // Bit 1 tracks whether words 63 and 64 carry content
        8'd53: identWord = {14'h0000, (s.advPio != 2'h0) || (s.dmaSup != 2'h0), 1'b1};
        8'd54: identWord = s.curCyl;
        8'd55: identWord = {8'h00, s.curHeads};
        8'd56: identWord = {8'h00, s.curSpt};
        8'd57: identWord = s.curCapacity[15:0];
        8'd58: identWord = s.curCapacity[31:16];
        8'd59: identWord = {7'h00, 1'b1, s.multiCur};
        8'd60: identWord = s.cardSectors[15:0];
        8'd61: identWord = s.cardSectors[31:16];
        // Only modes 0-2 ever shown here; higher modes live elsewhere
        8'd63: begin
          identWord[7:0] = dmaSupMask(s.dmaSup);
          if (s.dmaSel != IDT_DSEL_NONE) begin
            identWord[8 + int'(s.dmaSel)] = 1'b1;
          end
        end
        8'd64: identWord = {14'h0000, s.advPio};
        default: identWord = 16'h0000;
      endcase
    end
  endfunction : identWord

  // Register read decode, unmapped space reads zero
  function automatic logic [31:0] readReg(input idt_state_type s, input logic [11:0] a);
    readReg = 32'h0000_0000;
    if (a[11:10] == IDT_OFS_WINDOW[11:10]) begin
      readReg = {16'h0000, identWord(s, a[9:2])};
    end else begin
      unique case (a)
        IDT_OFS_DEFGEO:   readReg = {16'h0000, s.defSpt};
        IDT_OFS_CARDSECT: readReg = s.cardSectors;
        IDT_OFS_CURCHS:   readReg = {s.curSpt, s.curHeads, s.curCyl};
        IDT_OFS_MULTI:    readReg = {8'h00, s.multiCur, 7'h00, s.multiPref, s.multiMax};
        IDT_OFS_CTRL: begin
          readReg[IDT_CTL_STBY_BIT]                     = s.standby;
          readReg[IDT_CTL_IORDY_BIT]                    = s.iordy;
          readReg[IDT_CTL_PIO_LSB +: 2]                 = s.pioMode;
          readReg[IDT_CTL_DSEL_LSB +: 2]                = s.dmaSel;
          readReg[IDT_CTL_DSUP_LSB +: 2]                = s.dmaSup;
          readReg[IDT_CTL_APIO_LSB +: 2]                = s.advPio;
        end
        IDT_OFS_CURCAP:   readReg = s.curCapacity;
        default:          readReg = 32'h0000_0000;
      endcase
    end
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  //   Decode the address phase, land a
  //   pending write, then fetch read data
  //   from the updated copy; capacity is
  //   recomputed every cycle

  logic        addrTaken;
  logic        addrMapped;
  logic [6:0]  wrSlot;
  logic [1:0]  newPio;
  logic [1:0]  newSel;
  logic [1:0]  newSup;
  logic [47:0] product;

  // Decode notes
  //   Transfer type bit 1 marks a
  //   non-idle beat, sequential or not
  //   Write address and pending flag
  //   are held for the data phase
  //   Control fields are picked out of
  //   write data before clamping
  //
  // Address phase decode; upper address bits must be clear to hit the block
  always_comb begin
    addrTaken  = hsel && hready && htrans[1];
    addrMapped = (haddr[31:12] == 20'h00000);
    wrSlot     = textSlot(stateQ.wrAddr[9:2]);
    newPio     = hwdata[IDT_CTL_PIO_LSB +: 2];
    newSup     = hwdata[IDT_CTL_DSUP_LSB +: 2];
    newSel     = hwdata[IDT_CTL_DSEL_LSB +: 2];
    product    = 48'(stateQ.curCyl) * 48'(stateQ.curHeads) * 48'(stateQ.curSpt);
  end

  // Register update; writes land in the data phase, reads are fetched in the address phase
  always_comb begin
    stateD             = stateQ;
    stateD.readyOut    = 1'b1;
    // Product lags a geometry write by one cycle; a capacity read overlapping that write's data phase sees the old value
    stateD.curCapacity = product[31:0];
    stateD.wrPend      = addrTaken && hwrite && addrMapped;
    stateD.wrAddr      = haddr[11:0];
    if (stateQ.wrPend) begin
      if (stateQ.wrAddr >= IDT_OFS_WINDOW) begin
        // Only text slots inside the window take writes; the rest is fixed or live
        if (wrSlot[6] && stateQ.wrAddr[11:10] == 2'b01) begin
          stateD.text[wrSlot[5:0]] = hwdata[15:0];
        end
      end else begin
        unique case (stateQ.wrAddr)
          IDT_OFS_DEFGEO:   stateD.defSpt      = hwdata[15:0];
          IDT_OFS_CARDSECT: stateD.cardSectors = hwdata;
          IDT_OFS_CURCHS: begin
            stateD.curCyl   = hwdata[15:0];
            stateD.curHeads = hwdata[IDT_CHS_HEADS_LSB +: 8];
            stateD.curSpt   = hwdata[IDT_CHS_SPT_LSB +: 8];
          end
          IDT_OFS_MULTI: begin
            stateD.multiMax  = hwdata[7:0];
            stateD.multiPref = hwdata[IDT_MUL_PREF_BIT];
            stateD.multiCur  = hwdata[IDT_MUL_CUR_LSB +: 8];
          end
          IDT_OFS_CTRL: begin
            stateD.standby = hwdata[IDT_CTL_STBY_BIT];
            stateD.iordy   = hwdata[IDT_CTL_IORDY_BIT];
            // Reserved PIO codes are clamped to mode 2
            stateD.pioMode = (newPio > IDT_PIO_MAX) ? IDT_PIO_MAX : newPio;
            stateD.dmaSup  = newSup;
            // A selection beyond the supported set reads as no selection
            stateD.dmaSel  = (newSel < newSup) ? newSel : IDT_DSEL_NONE;
            stateD.advPio  = hwdata[IDT_CTL_APIO_LSB +: 2];
          end
          default: ;
        endcase
      end
    end
    // Fetched after the write so a read on the landing edge sees it
    if (addrTaken && !hwrite) begin
      stateD.rdata = addrMapped ? readReg(stateD, haddr[11:0]) : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing
  //   No wait states, ready always high
  //   Taken: select, ready, non-idle
  //   Read data loaded at address edge
  //   Read data stands until next read
  //   Write data taken at data edge
  //   Read after write sees new value
  //   Capacity trails geometry by one
  //   Transfer size ignored
  //   Response always okay
  //   Address and data phases of two
  //   transfers may overlap
  //
  // Reset behaviour
  //   Synchronous, active low
  //   Hold for one edge at least
  //   Geometry and counts to defaults
  //   Preferred flag set on reset
  //   Dma selection to none
  //   Modes and flags cleared
  //   Text words to spaces
  //   Read data cleared, no stale leak
  //   Ready stays high throughout
  //
  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stateQ             <= '0;
      stateQ.defSpt      <= IDT_RST_DEFSPT;
      stateQ.cardSectors <= IDT_RST_CARDSECT;
      stateQ.curCyl      <= IDT_RST_CYL;
      stateQ.curHeads    <= IDT_RST_HEADS;
      stateQ.curSpt      <= IDT_RST_SPT;
      stateQ.multiMax    <= IDT_RST_MULMAX;
      stateQ.multiPref   <= 1'b1;
      stateQ.multiCur    <= IDT_RST_MULCUR;
      stateQ.dmaSel      <= IDT_DSEL_NONE;
      stateQ.text        <= {IDT_TEXT_WORDS{IDT_RST_TEXT}};
      stateQ.readyOut    <= 1'b1;
    end else begin
      stateQ <= stateD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output notes
  //   Ready and read data from flops
  //   Response tied to okay
  //   Window reads leave upper half zero
  //
  // Bus outputs, straight from the state flops; response always OKAY
  always_comb begin
    hreadyout = stateQ.readyOut;
    hresp     = 1'b0;
    hrdata    = stateQ.rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limitations and trade-offs
  //   Capacity is registered, but reads take
  //   the next-state product, so the
  //   multiplier sits on the read path
  //   Only 32 product bits are kept;
  //   16x8x8 geometry never exceeds them
  //   Reserved pio codes are clamped, not
  //   refused, so the word stays legal
  //   A dma selection outside the support
  //   set reads back as none
  //   Advanced pio bits kept as written
  //   Writes outside text ranges are lost
  //   Writes to live words are lost
  //   No error response is ever given
  //   Window slots past 7fc read zero
  //   Upper address bits must be clear
  //   Byte lanes and size are ignored
  //   Two transfers may overlap in phase
  //
  // Extension notes
  //   Words 65 up belong to other logic
  //   Higher dma modes are reported
  //   elsewhere; pio 3 and 4 in word 64
  //   Control bits 31-18 are free
  //   New registers start at 018
  //   Text slots fixed at thirty-four

endmodule : idt_identify_words

`default_nettype wire

// ===== logic/idt_pkg.sv
// Package with constants, field layouts and state types of the identify data block
package idt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] IDT_OFS_DEFGEO   = 12'h000;
  localparam logic [11:0] IDT_OFS_CARDSECT = 12'h004;
  localparam logic [11:0] IDT_OFS_CURCHS   = 12'h008;
  localparam logic [11:0] IDT_OFS_MULTI    = 12'h00c;
  localparam logic [11:0] IDT_OFS_CTRL     = 12'h010;
  localparam logic [11:0] IDT_OFS_CURCAP   = 12'h014;
  localparam logic [11:0] IDT_OFS_WINDOW   = 12'h400;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int IDT_CHS_HEADS_LSB = 16;
  localparam int IDT_CHS_SPT_LSB   = 24;
  localparam int IDT_MUL_PREF_BIT  = 8;
  localparam int IDT_MUL_CUR_LSB   = 16;
  localparam int IDT_CTL_STBY_BIT  = 0;
  localparam int IDT_CTL_IORDY_BIT = 1;
  localparam int IDT_CTL_PIO_LSB   = 4;
  localparam int IDT_CTL_DSEL_LSB  = 8;
  localparam int IDT_CTL_DSUP_LSB  = 12;
  localparam int IDT_CTL_APIO_LSB  = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Identify word numbers and fixed values
  localparam int              IDT_TEXT_WORDS = 34;
  localparam logic [15:0]     IDT_ECC_COUNT  = 16'h0004;
  localparam logic [7:0]      IDT_SPACE      = 8'h20;
  localparam logic [7:0]      IDT_MUL_PREF   = 8'h80;
  localparam logic [1:0]      IDT_PIO_MAX    = 2'h2;
  localparam logic [1:0]      IDT_DSEL_NONE  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] IDT_RST_DEFSPT   = 16'h0020;
  localparam logic [31:0] IDT_RST_CARDSECT = 32'h0000_0000;
  localparam logic [15:0] IDT_RST_CYL      = 16'h0000;
  localparam logic [7:0]  IDT_RST_HEADS    = 8'h00;
  localparam logic [7:0]  IDT_RST_SPT      = 8'h00;
  localparam logic [7:0]  IDT_RST_MULMAX   = 8'h01;
  localparam logic [7:0]  IDT_RST_MULCUR   = 8'h00;
  localparam logic [15:0] IDT_RST_TEXT     = 16'h2020;

  ////////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    logic [15:0]                     defSpt;
    logic [31:0]                     cardSectors;
    logic [15:0]                     curCyl;
    logic [7:0]                      curHeads;
    logic [7:0]                      curSpt;
    logic [31:0]                     curCapacity;
    logic [7:0]                      multiMax;
    logic                            multiPref;
    logic [7:0]                      multiCur;
    logic                            standby;
    logic                            iordy;
    logic [1:0]                      pioMode;
    logic [1:0]                      dmaSel;
    logic [1:0]                      dmaSup;
    logic [1:0]                      advPio;
    logic [IDT_TEXT_WORDS-1:0][15:0] text;
    logic                            wrPend;
    logic [11:0]                     wrAddr;
    logic                            readyOut;
    logic [31:0]                     rdata;
  } idt_state_type;

endpackage : idt_pkg

// ===== logic/idt_pkg_unused_guard.sv
// Intentionally empty companion file; no logic
`default_nettype none
`default_nettype wire

// ===== verif/idt_checker.sv
// Concurrent checks on the identify data slave ports
`timescale 1ns/100ps
`default_nettype none

module idt_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata
);
  logic        rdHit_q;
  logic [31:0] rdAddr_q;
  logic        winRd;
  logic [7:0]  rdWord;

  ////////////////////////////////////////////////////////////////////////////
  // Track the read whose data phase is current
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdHit_q <= 1'b0;
    end else begin
      rdHit_q <= hsel & hready & htrans[1] & ~hwrite;
    end
    rdAddr_q <= haddr;
  end

  // Window reads only; register reads are left to the bench
  assign winRd  = rdHit_q && (rdAddr_q[31:10] == 22'h1);
  assign rdWord = rdAddr_q[9:2];

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  AST_ECC: assert property (winRd && rdWord == 8'd22 |-> hrdata == 32'h0000_0004)
    else $error("ecc count word wrong");
  AST_MUL47: assert property (winRd && rdWord == 8'd47 |-> hrdata[31:16] == 16'h0 &&
    (hrdata[15:8] == 8'h80 || hrdata[15:8] == 8'h00)) else $error("multiple count word upper byte wrong");
  AST_CAP_FIXED: assert property (winRd && rdWord == 8'd49 |-> hrdata[10:8] == 3'b010)
    else $error("capability fixed bits wrong");
  AST_CAP_RSVD: assert property (winRd && rdWord == 8'd49 |-> {hrdata[31:14], hrdata[12], hrdata[7:0]} == 27'h0)
    else $error("capability reserved bits set");
  AST_PIO: assert property (winRd && rdWord == 8'd51 |-> hrdata[15:8] <= 8'h02 && hrdata[7:0] == 8'h0)
    else $error("pio mode field out of range");
  AST_VALID: assert property (winRd && rdWord == 8'd53 |-> hrdata[0] && hrdata[31:2] == 30'h0)
    else $error("validity word wrong");
  AST_MULSET: assert property (winRd && rdWord == 8'd59 |-> hrdata[31:8] == 24'h000001)
    else $error("multiple setting word wrong");
  AST_DMA_SEL: assert property (winRd && rdWord == 8'd63 |-> $onehot0(hrdata[10:8]) && hrdata[31:11] == 21'h0)
    else $error("dma selection not one-hot");
  AST_DMA_SUP: assert property (winRd && rdWord == 8'd63 |-> hrdata[7:0] inside {8'h00, 8'h01, 8'h03, 8'h07})
    else $error("dma support not cumulative");
  AST_ADVPIO: assert property (winRd && rdWord == 8'd64 |-> hrdata[31:2] == 30'h0)
    else $error("advanced pio reserved bits set");
  AST_RSVD_WORD: assert property (winRd && rdWord inside {8'd9, 8'd20, 8'd21, 8'd48, 8'd50, 8'd52, 8'd62}
    |-> hrdata == 32'h0) else $error("reserved word not zero");
  AST_HOLD: assert property (!rdHit_q |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule : idt_checker

`default_nettype wire

// ===== verif/idt_host_model.sv
// Host side bus master issuing single word transfers
`timescale 1ns/100ps
`default_nettype none

module idt_host_model (
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int idleGap;

  // Idle bus at time zero
  initial begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    idleGap = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer; a slow host waits idleGap cycles first
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    repeat (idleGap) @(posedge clock);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    // Unused write data toggles so nothing leans on stale values
    hwdata <= wr ? wdata : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    rdata = hrdata;
    hsel  <= 1'b0;
  endtask : xfer
endmodule : idt_host_model

`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the identify data words slave
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import idt_pkg::*;
  logic        clock;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rv;
  int          failures;
  int          samples_checked;

  idt_host_model host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  idt_identify_words dut (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, {20'h0, a}, d, rv);
  endtask : wr

  task automatic rr(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, {20'h0, a}, 32'h0, rv);
    chk(rv, exp);
  endtask : rr

  // Identify word w sits at window base plus four times w
  task automatic rw(input int w, input logic [31:0] exp);
    rr(IDT_OFS_WINDOW + 12'(w * 4), exp);
  endtask : rw

  task automatic results;
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] sup;
    logic [1:0] sel;
    int         rsv[8];
    rsv = '{9, 20, 21, 48, 50, 52, 62, 65};
    failures = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    // Contents straight after reset
    rw(6, 32'h20);
    rw(47, 32'h8001);
    rw(59, 32'h100);
    rw(53, 32'h1);
    rw(22, 32'h4);
    rw(10, 32'h2020);
    rw(49, 32'h200);
    // Geometry, capacity and an aliasing write outside the block
    wr(IDT_OFS_DEFGEO, 32'h3f);
    host.xfer(1'b1, 32'h0000_1000, 32'h55, rv);
    rw(6, 32'h3f);
    host.xfer(1'b0, 32'h0000_1000, 32'h0, rv);
    chk(rv, 32'h0);
    // Slot past the window must not alias word 22
    host.xfer(1'b0, 32'h0000_0858, 32'h0, rv);
    chk(rv, 32'h0);
    wr(IDT_OFS_CARDSECT, 32'h0012_3456);
    rw(60, 32'h3456);
    rw(61, 32'h12);
    rw(7, 32'h3456);
    rw(8, 32'h12);
    wr(IDT_OFS_CURCHS, 32'h3f10_0100);
    rw(54, 32'h100);
    rw(55, 32'h10);
    rw(56, 32'h3f);
    rw(57, 32'hf000);
    rw(58, 32'h3);
    wr(IDT_OFS_CURCAP, 32'h0);
    rr(IDT_OFS_CURCAP, 32'h3f000);
    wr(IDT_OFS_MULTI, 32'h0008_0010);
    rw(47, 32'h10);
    rw(59, 32'h108);
    // Every support count against every selection and pio code
    for (int i = 0; i < 16; i++) begin
      sup = 2'(i >> 2);
      sel = 2'(i);
      wr(IDT_OFS_CTRL, (32'(sup) << 16) | (32'(sup) << 12) | (32'(sel) << 8) | (32'(sel) << 4) | 32'(i & 3));
      rw(49, 32'h200 | (32'(i & 1) << 13) | (32'((i >> 1) & 1) << 11));
      rw(51, (sel > 2'h2) ? 32'h200 : (32'(sel) << 8));
      rw(53, (sup != 2'h0) ? 32'h3 : 32'h1);
      rw(63, ((32'h1 << sup) - 32'h1) | ((sel < sup) ? (32'h100 << sel) : 32'h0));
      rw(64, 32'(sup));
    end
    // Text words with zero bytes padded to spaces
    wr(12'h428, 32'h41);
    rw(10, 32'h2041);
    wr(12'h45c, 32'h3132);
    rw(23, 32'h3132);
    wr(12'h4b8, 32'h4d00);
    rw(46, 32'h4d20);
    // Fixed and reserved words, with a slow host
    host.idleGap = 3;
    wr(12'h458, 32'hffff);
    rw(22, 32'h4);
    foreach (rsv[k]) rw(rsv[k], 32'h0);
    host.idleGap = 0;
    // Second reset in mid-run
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rw(6, 32'h20);
    rw(63, 32'h0);
    results();
  end
endmodule : tb_top

bind idt_identify_words idt_checker u_chk (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata));

`default_nettype wire
